// ==== include/ssr_pkg.sv ====
// Package: constants and carriers for the status register set bank
//==========================================================
package ssr_pkg;

   //==========================================================
   // Sizes
   localparam int DATA_W = 16;
   localparam int NUM_SETS = 11;
   localparam int SEL_W = 4;

   //==========================================================
   // Preset values applied at power-on and status preset; the event reset value only at power-on
   localparam logic [15:0] PTR_PRESET = 16'h7FFF;
   localparam logic [15:0] NTR_PRESET = 16'h0000;
   localparam logic [15:0] ENA_PRESET = 16'h0000;
   localparam logic [15:0] EVT_RESET = 16'h0000;
   localparam logic [15:0] VALUE_MASK = 16'h7FFF;
   localparam logic QUE_PRESET = 1'b1;

   //==========================================================
   // Sub-actions; the first code is the bare selection
   typedef enum logic [2:0] {
      SSR_EVT_RD,
      SSR_COND_RD,
      SSR_ENA_WR,
      SSR_ENA_RD,
      SSR_NTR_WR,
      SSR_NTR_RD,
      SSR_PTR_WR,
      SSR_PTR_RD
   } ssr_act_type;

   // Command from the status command decoder
   typedef struct packed {
      logic valid;
      logic [SEL_W-1:0] sel;
      ssr_act_type act;
      logic [DATA_W-1:0] data;
   } ssr_cmd_type;

   // Answer to a read
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } ssr_rsp_type;

endpackage

// ==== design/ssr_status_sets.sv ====
// Module: bank of status register sets with command decode and answers
`timescale 1ns/100ps
module ssr_status_sets
#(
   parameter int NUM_SETS = ssr_pkg::NUM_SETS
)
(
   input wire logic clk,
   input wire logic rst,
   input wire ssr_pkg::ssr_cmd_type cmd,
   input wire logic [NUM_SETS-1:0][15:0] cond,
   input wire logic statusPreset,
   input wire logic clearStatus,
   output ssr_pkg::ssr_rsp_type rsp,
   output logic [NUM_SETS-1:0] summary,
   output logic queueEnable,
   output logic queueClear,
   output logic commonMaskClear
);

   //==========================================================
   // Parameter check
   initial
   begin
      if (NUM_SETS < 1 || NUM_SETS > (1 << ssr_pkg::SEL_W))
      begin
         $error("NUM_SETS out of range for the selector width");
      end
   end

   //==========================================================
   // Storage per set
   logic [NUM_SETS-1:0][15:0] evt;
   logic [NUM_SETS-1:0][15:0] ena;
   logic [NUM_SETS-1:0][15:0] ntr;
   logic [NUM_SETS-1:0][15:0] ptr;
   logic [NUM_SETS-1:0][15:0] prevCond;
   logic [NUM_SETS-1:0][15:0] newEvt;
   logic [NUM_SETS-1:0] hit;
   logic primed;
   logic [15:0] next_rdData;

   // Edge detection waits one cycle after reset so a level already
   // present at power-on is not mistaken for a rise
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         primed <= 1'b0;
      end
      else
      begin
         primed <= 1'b1;
      end
   end

   //==========================================================
   // Per-set logic
   genvar g;
   generate
      for (g = 0; g < NUM_SETS; g = g + 1)
      begin : gSet
         // Only the named set sees the action
         // Compared as integers because a genvar cannot be part-selected
         assign hit[g] = cmd.valid &&
            (int'(cmd.sel) == g);

         // Edges gated by the edge selects
         assign newEvt[g] = primed ? (ssr_pkg::VALUE_MASK &
            ((~cond[g] & prevCond[g] & ntr[g]) |
             (cond[g] & ~prevCond[g] & ptr[g])))
            : 16'h0000;

         // Previous level for edge detection
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               prevCond[g] <= 16'h0000;
            end
            else
            begin
               prevCond[g] <= cond[g];
            end
         end

         // Latched events: a new edge wins over read or clear-status
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               evt[g] <= ssr_pkg::EVT_RESET;
            end
            else if (clearStatus ||
               (hit[g] && cmd.act == ssr_pkg::SSR_EVT_RD))
            begin
               evt[g] <= newEvt[g];
            end
            else
            begin
               evt[g] <= evt[g] | newEvt[g];
            end
         end

         // Mask: preset wins over a write in the same cycle
         always_ff @(posedge clk)
         begin
            if (rst || statusPreset)
            begin
               ena[g] <= ssr_pkg::ENA_PRESET;
            end
            else if (hit[g] && cmd.act == ssr_pkg::SSR_ENA_WR)
            begin
               ena[g] <= cmd.data & ssr_pkg::VALUE_MASK;
            end
         end

         // Falling-edge select
         always_ff @(posedge clk)
         begin
            if (rst || statusPreset)
            begin
               ntr[g] <= ssr_pkg::NTR_PRESET;
            end
            else if (hit[g] && cmd.act == ssr_pkg::SSR_NTR_WR)
            begin
               ntr[g] <= cmd.data & ssr_pkg::VALUE_MASK;
            end
         end

         // Rising-edge select
         always_ff @(posedge clk)
         begin
            if (rst || statusPreset)
            begin
               ptr[g] <= ssr_pkg::PTR_PRESET;
            end
            else if (hit[g] && cmd.act == ssr_pkg::SSR_PTR_WR)
            begin
               ptr[g] <= cmd.data & ssr_pkg::VALUE_MASK;
            end
         end

         // Summary toward the parent set, one cycle behind the events
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               summary[g] <= 1'b0;
            end
            else
            begin
               summary[g] <= |(evt[g] & ena[g]);
            end
         end

         // Write stores exactly the low 15 bits
         chk_mask_write: assert property
            (@(posedge clk) disable iff (rst)
            hit[g] && cmd.act == ssr_pkg::SSR_ENA_WR && !statusPreset
            |=> ena[g] == ($past(cmd.data) & 16'h7FFF))
            else $error("enable write stored wrong value");

         chk_fall_write: assert property
            (@(posedge clk) disable iff (rst)
            hit[g] && cmd.act == ssr_pkg::SSR_NTR_WR && !statusPreset
            |=> ntr[g] == ($past(cmd.data) & 16'h7FFF))
            else $error("falling select write stored wrong value");

         chk_rise_write: assert property
            (@(posedge clk) disable iff (rst)
            hit[g] && cmd.act == ssr_pkg::SSR_PTR_WR && !statusPreset
            |=> ptr[g] == ($past(cmd.data) & 16'h7FFF))
            else $error("rising select write stored wrong value");

         chk_event_clear: assert property
            (@(posedge clk) disable iff (rst)
            hit[g] && cmd.act == ssr_pkg::SSR_EVT_RD
            |=> evt[g] == $past(newEvt[g]))
            else $error("event read did not clear the events");

         chk_edge_latch: assert property
            (@(posedge clk) disable iff (rst)
            newEvt[g] != 16'h0000
            |=> (evt[g] & $past(newEvt[g])) == $past(newEvt[g]))
            else $error("selected edge was not latched");

         chk_preset_load: assert property
            (@(posedge clk) disable iff (rst)
            statusPreset |=> ptr[g] == 16'h7FFF && ntr[g] == 16'h0000
            && ena[g] == 16'h0000)
            else $error("status preset did not load presets");

         chk_clear_keeps: assert property
            (@(posedge clk) disable iff (rst)
            clearStatus && !statusPreset && !hit[g]
            |=> $stable(ena[g]) && $stable(ntr[g]) && $stable(ptr[g]))
            else $error("clear-status touched masks or selects");

         chk_summary_or: assert property
            (@(posedge clk) disable iff (rst)
            ##1 summary[g] == |($past(evt[g]) & $past(ena[g])))
            else $error("summary does not follow masked events");

         chk_top_bit: assert property
            (@(posedge clk) disable iff (rst)
            !ena[g][15] && !ntr[g][15] && !ptr[g][15] && !evt[g][15])
            else $error("bit 15 of a stored register is set");
      end
   endgenerate

   //==========================================================
   // Read multiplexer; an unknown selection answers zero
   always_comb
   begin
      next_rdData = 16'h0000;
      for (int i = 0; i < NUM_SETS; i++)
      begin
         if (cmd.sel == i[ssr_pkg::SEL_W-1:0])
         begin
            case (cmd.act)
               ssr_pkg::SSR_COND_RD: next_rdData = cond[i];
               ssr_pkg::SSR_EVT_RD: next_rdData = evt[i];
               ssr_pkg::SSR_ENA_RD: next_rdData = ena[i];
               ssr_pkg::SSR_NTR_RD: next_rdData = ntr[i];
               ssr_pkg::SSR_PTR_RD: next_rdData = ptr[i];
               default: next_rdData = 16'h0000;
            endcase
         end
      end
   end

   // Answer one cycle after every command; writes answer zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rsp <= '0;
      end
      else
      begin
         rsp.valid <= cmd.valid;
         rsp.data <= next_rdData & ssr_pkg::VALUE_MASK;
      end
   end

   //==========================================================
   // Device-wide status controls
   // Queue enable ignores clear-status
   always_ff @(posedge clk)
   begin
      if (rst || statusPreset)
      begin
         queueEnable <= ssr_pkg::QUE_PRESET;
      end
   end

   // Queue and common status clear pulse, held through power-on
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         queueClear <= 1'b1;
      end
      else
      begin
         queueClear <= clearStatus;
      end
   end

   // Common enable masks clear only at power-on
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         commonMaskClear <= 1'b1;
      end
      else
      begin
         commonMaskClear <= 1'b0;
      end
   end

   //==========================================================
   // Answer timing and content
   chk_answer_next: assert property
      (@(posedge clk) disable iff (rst)
      cmd.valid |=> rsp.valid)
      else $error("command not answered next cycle");

   // A selection past the last set must not borrow another set's data
   chk_refused_zero: assert property
      (@(posedge clk) disable iff (rst)
      cmd.valid && int'(cmd.sel) >= NUM_SETS |=> rsp.data == 16'h0000)
      else $error("refused selection answered nonzero data");

   chk_cond_read: assert property
      (@(posedge clk) disable iff (rst)
      cmd.valid && cmd.act == ssr_pkg::SSR_COND_RD && cmd.sel == 4'h0
      |=> rsp.data == ($past(cond[0]) & 16'h7FFF))
      else $error("condition read returned wrong value");

   chk_mask_clear: assert property
      (@(posedge clk)
      $fell(rst) |-> commonMaskClear ##1 !commonMaskClear)
      else $error("common mask clear not a power-on pulse");

endmodule

// ==== testbench/ssr_controller.sv ====
// Partner: remote controller model turning requests into command strobes
`timescale 1ns/100ps
module ssr_controller
(
   input wire logic reqValid,
   input wire logic [3:0] reqSel,
   input wire ssr_pkg::ssr_act_type reqAct,
   input wire logic [15:0] reqData,
   output ssr_pkg::ssr_cmd_type cmd
);
   //==========================================================
   // Group prefix rides in sel; no sub-action means the event code
   always_comb
   begin
      cmd.valid = reqValid;
      cmd.sel = reqSel;
      cmd.act = reqAct;
      // Reads carry junk data so a design must not depend on it
      cmd.data = (reqAct inside {ssr_pkg::SSR_ENA_WR, ssr_pkg::SSR_NTR_WR,
         ssr_pkg::SSR_PTR_WR}) ? reqData : ~reqData;
   end
endmodule

// ==== testbench/ssr_status_sets_test.sv ====
// Testbench: table and directed checks of the status register sets
`timescale 1ns/100ps
module ssr_status_sets_test;
   typedef struct packed
   {
      logic [3:0] sel;
      ssr_pkg::ssr_act_type act;
      logic [15:0] data;
      logic [15:0] expData;
   } ssr_row_type;
   logic clk;
   logic rst;
   logic statusPreset;
   logic clearStatus;
   logic reqValid;
   logic [3:0] reqSel;
   ssr_pkg::ssr_act_type reqAct;
   logic [15:0] reqData;
   logic [10:0][15:0] cond;
   ssr_pkg::ssr_cmd_type cmd;
   ssr_pkg::ssr_rsp_type rsp;
   logic [10:0] summary;
   logic queueEnable;
   logic queueClear;
   logic commonMaskClear;
   int nErrors;
   int checked;
   ssr_row_type rows [12];

   ssr_controller ctl (.reqValid(reqValid), .reqSel(reqSel),
      .reqAct(reqAct), .reqData(reqData), .cmd(cmd));
   ssr_status_sets #(.NUM_SETS(11)) dut (.clk(clk), .rst(rst), .cmd(cmd),
      .cond(cond), .statusPreset(statusPreset), .clearStatus(clearStatus),
      .rsp(rsp), .summary(summary), .queueEnable(queueEnable),
      .queueClear(queueClear), .commonMaskClear(commonMaskClear));

   //==========================================================
   // Clock, 5 ns period
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   //==========================================================
   // Shared tasks; every drive lands 1 ns after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input string name, input logic [15:0] exp,
      input logic [15:0] seen);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         nErrors++;
      end
   endtask

   // One command; valid drops a cycle later so it is never set twice at once
   task automatic issue(input logic [3:0] sel, input ssr_pkg::ssr_act_type act,
      input logic [15:0] data, input logic [15:0] exp);
      reqValid = 1'b1;
      reqSel = sel;
      reqAct = act;
      reqData = data;
      step(1);
      check("rsp.valid", 16'h0001, {15'h0000, rsp.valid});
      check("rsp.data", exp, rsp.data);
      reqValid = 1'b0;
      step(1);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   //==========================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      statusPreset = 1'b0;
      clearStatus = 1'b0;
      reqValid = 1'b0;
      reqSel = 4'h0;
      reqAct = ssr_pkg::SSR_EVT_RD;
      reqData = 16'h0000;
      cond = '0;
      nErrors = 0;
      checked = 0;
      rows = '{
         '{4'h3, ssr_pkg::SSR_PTR_RD, 16'h0000, 16'h7FFF},
         '{4'h3, ssr_pkg::SSR_NTR_RD, 16'h0000, 16'h0000},
         '{4'h3, ssr_pkg::SSR_ENA_RD, 16'h0000, 16'h0000},
         '{4'h3, ssr_pkg::SSR_ENA_WR, 16'hFFFF, 16'h0000},
         '{4'h3, ssr_pkg::SSR_ENA_RD, 16'h0000, 16'h7FFF},
         '{4'h3, ssr_pkg::SSR_NTR_WR, 16'h8005, 16'h0000},
         '{4'h3, ssr_pkg::SSR_NTR_RD, 16'h0000, 16'h0005},
         '{4'h3, ssr_pkg::SSR_PTR_WR, 16'h800A, 16'h0000},
         '{4'h3, ssr_pkg::SSR_PTR_RD, 16'h0000, 16'h000A},
         '{4'h4, ssr_pkg::SSR_ENA_RD, 16'h0000, 16'h0000},
         '{4'hB, ssr_pkg::SSR_ENA_RD, 16'h0000, 16'h0000},
         '{4'h3, ssr_pkg::SSR_COND_RD, 16'h0000, 16'h0000}};
      step(2);
      check("commonMaskClear", 16'h0001, {15'h0000, commonMaskClear});
      rst = 1'b0;
      step(1);
      check("queueClear", 16'h0000, {15'h0000, queueClear});
      check("queueEnable", 16'h0001, {15'h0000, queueEnable});
      foreach (rows[i])
         issue(rows[i].sel, rows[i].act, rows[i].data, rows[i].expData);
      $display("test table done");
      // Rising then falling edges through both selects, bit 15 masked
      cond[3] = 16'h800F;
      step(3);
      check("summary", 16'h0008, {5'h00, summary});
      issue(4'h3, ssr_pkg::SSR_COND_RD, 16'h0000, 16'h000F);
      issue(4'h3, ssr_pkg::SSR_COND_RD, 16'h0000, 16'h000F);
      cond[3] = 16'h0000;
      step(3);
      issue(4'h3, ssr_pkg::SSR_EVT_RD, 16'h0000, 16'h000F);
      issue(4'h3, ssr_pkg::SSR_EVT_RD, 16'h0000, 16'h0000);
      check("summary", 16'h0000, {5'h00, summary});
      $display("test edges done");
      // Clear-status wipes events but leaves the enable mask
      cond[3] = 16'h0002;
      step(3);
      clearStatus = 1'b1;
      step(1);
      clearStatus = 1'b0;
      check("queueClear", 16'h0001, {15'h0000, queueClear});
      step(1);
      issue(4'h3, ssr_pkg::SSR_EVT_RD, 16'h0000, 16'h0000);
      issue(4'h3, ssr_pkg::SSR_ENA_RD, 16'h0000, 16'h7FFF);
      $display("test clear done");
      // Preset restores masks and selects but keeps latched events
      cond[3] = 16'h000A;
      step(3);
      statusPreset = 1'b1;
      step(1);
      statusPreset = 1'b0;
      step(1);
      check("queueEnable", 16'h0001, {15'h0000, queueEnable});
      check("queueClear", 16'h0000, {15'h0000, queueClear});
      issue(4'h3, ssr_pkg::SSR_EVT_RD, 16'h0000, 16'h0008);
      issue(4'h3, ssr_pkg::SSR_ENA_RD, 16'h0000, 16'h0000);
      issue(4'h3, ssr_pkg::SSR_PTR_RD, 16'h0000, 16'h7FFF);
      issue(4'h3, ssr_pkg::SSR_NTR_RD, 16'h0000, 16'h0000);
      $display("test preset done");
      // Power-on in mid-run
      issue(4'h5, ssr_pkg::SSR_NTR_WR, 16'h1234, 16'h0000);
      rst = 1'b1;
      step(1);
      check("commonMaskClear", 16'h0001, {15'h0000, commonMaskClear});
      rst = 1'b0;
      step(2);
      issue(4'h5, ssr_pkg::SSR_NTR_RD, 16'h0000, 16'h0000);
      $display("test power-on done");
      test_done();
   end
endmodule
